// ---- verilog/hsc_top.sv ----
// Halt standby controller top: bus slave, halt sequencer, clock gating
// Overview of operation
// RULE_01: In halt the processor clock enable is held off.
// RULE_02: Port latch outputs hold their value through halt.
// RULE_03: Counter a runs in halt without high-speed only on its pin.
// RULE_04: Counter b runs in halt without high-speed only on its pin.
// RULE_05: Timer a runs then only when fed by a running counter a.
// RULE_06: Timer b in halt depends on which oscillators run and its source.
// RULE_07: Watch timer runs then only from the subsystem clock.
// RULE_08: Non-stoppable option keeps the watchdog running with the osc.
// RULE_09: Stoppable option stops the watchdog for all of halt.
// RULE_10: Async ports run then only from a running counter a output.
// RULE_11: Clocked serial port runs then only from its external clock pin.
// RULE_12: Any unmasked interrupt request ends halt.
// RULE_13: With global enable set the wake leads to vectored servicing.
// RULE_14: With global enable clear execution resumes at the next step.
// RULE_15: Vectored wake inserts a wait of 8 or 9 clocks.
// RULE_16: Non-vectored wake inserts a wait of 2 or 3 clocks.
// RULE_17: External reset ends halt and restarts from the reset vector.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module hsc_top #(
	parameter int NIRQ = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [NIRQ-1:0] irq_req_i,
	input wire logic [NIRQ-1:0] irq_mask_i,
	input wire logic hs_run_i,
	input wire logic int_run_i,
	input wire logic cnta_run_i,
	output logic cpu_clk_en_o,
	output logic vector_take_o,
	output logic resume_o,
	output logic reset_vector_o,
	output logic [7:0] port_o,
	output hsc_pkg::hsc_periph_s periph_run_o
);
	hsc_pkg::hsc_state_e state, next_state;
	logic [3:0] wait_cnt, next_wait_cnt;
	logic gie, next_gie;
	logic wdt_opt, next_wdt_opt;
	logic [7:0] csel, next_csel;
	logic [7:0] port_latch, next_port_latch;
	logic vec_pend, next_vec_pend;
	logic ack, next_ack;
	logic bus_wait, next_bus_wait;
	logic [31:0] rdata, next_rdata;
	logic cpu_en, next_cpu_en;
	logic vec_pulse, next_vec_pulse;
	logic res_pulse, next_res_pulse;
	logic rvec, next_rvec;
	logic [2:0] osc_sync;
	hsc_pkg::hsc_osc_s osc;
	hsc_pkg::hsc_periph_s run_comb;
	logic wake;
	logic access;
	logic halt_cmd;

	// All checks below run on the core clock and pause in reset
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// Oscillator status comes from another clock world
	hsc_sync #(
		.WIDTH(3)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.d_i({hs_run_i, int_run_i, cnta_run_i}),
		.q_o(osc_sync)
	);
	assign osc = hsc_pkg::hsc_osc_s'(osc_sync);

	hsc_gate u_gate (
		.halted_i(state == hsc_pkg::ST_HALT),
		.osc_i(osc),
		.csel_i(csel),
		.wdt_opt_i(wdt_opt),
		.run_o(run_comb)
	);

	// Wake and halt requests, decoded from this cycle's inputs
	assign wake = |(irq_req_i & ~irq_mask_i); // RULE_12
	assign access = (avs_read_i || avs_write_i) && !ack;
	assign halt_cmd = access && avs_write_i &&
		avs_address_i == hsc_pkg::ADDR_CTRL &&
		avs_writedata_i[hsc_pkg::CTRL_HALT_BIT];

	// Bus slave: one wait cycle, then acknowledge
	always_comb begin
		next_ack = access;
		next_bus_wait = !access; // Registered stall, never from a gate
		next_gie = gie;
		next_wdt_opt = wdt_opt;
		next_csel = csel;
		next_port_latch = port_latch;
		next_rdata = rdata;
		if (access && avs_write_i) begin
			unique case (avs_address_i)
				hsc_pkg::ADDR_CTRL: begin
					next_gie = avs_writedata_i[hsc_pkg::CTRL_GIE_BIT];
					next_wdt_opt = avs_writedata_i[hsc_pkg::CTRL_WDT_OPT_BIT];
				end
				hsc_pkg::ADDR_CSEL: next_csel = avs_writedata_i[7:0];
				// Port writes outside ST_RUN are refused, so the latch is frozen
				hsc_pkg::ADDR_PORT: begin
					if (state == hsc_pkg::ST_RUN)
						next_port_latch = avs_writedata_i[7:0]; // RULE_02
				end
				default: ;
			endcase
		end
		if (access && avs_read_i) begin
			unique case (avs_address_i)
				hsc_pkg::ADDR_CTRL: next_rdata = {29'h0, wdt_opt, gie, 1'b0};
				hsc_pkg::ADDR_STAT: next_rdata = {24'h0, wait_cnt,
					osc_sync, state == hsc_pkg::ST_HALT};
				hsc_pkg::ADDR_CSEL: next_rdata = {24'h0, csel};
				hsc_pkg::ADDR_PORT: next_rdata = {24'h0, port_latch};
				default: next_rdata = hsc_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// Halt sequencer
	always_comb begin
		next_state = state;
		next_wait_cnt = wait_cnt;
		next_vec_pend = vec_pend;
		next_cpu_en = cpu_en;
		next_vec_pulse = 1'b0;
		next_res_pulse = 1'b0;
		next_rvec = 1'b0;
		unique case (state)
			hsc_pkg::ST_RUN: begin
				next_cpu_en = 1'b1;
				if (halt_cmd && !wake) begin
					next_state = hsc_pkg::ST_HALT;
					next_cpu_en = 1'b0; // RULE_01
				end
			end
			hsc_pkg::ST_HALT: begin
				next_cpu_en = 1'b0; // RULE_01
				if (wake) begin
					next_state = hsc_pkg::ST_WAIT;
					next_vec_pend = gie; // RULE_13 RULE_14
					next_wait_cnt = gie ? hsc_pkg::WAIT_VECTOR - 4'h1
						: hsc_pkg::WAIT_RESUME - 4'h1; // RULE_15 RULE_16
				end
			end
			hsc_pkg::ST_WAIT: begin
				if (wait_cnt == 4'h0) begin
					next_state = hsc_pkg::ST_RUN;
					next_cpu_en = 1'b1;
					next_vec_pulse = vec_pend; // RULE_13
					next_res_pulse = !vec_pend; // RULE_14
				end else begin
					next_wait_cnt = wait_cnt - 4'h1;
				end
			end
		endcase
	end

	// Reset aborts halt and raises the reset vector request
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= hsc_pkg::ST_RUN; // RULE_17
			wait_cnt <= 4'h0;
			vec_pend <= 1'b0;
			cpu_en <= 1'b0;
			vec_pulse <= 1'b0;
			res_pulse <= 1'b0;
			rvec <= 1'b1; // RULE_17
			ack <= 1'b0;
			bus_wait <= 1'b1;
			gie <= 1'b0;
			wdt_opt <= 1'b0;
			csel <= hsc_pkg::CSEL_RESET;
			port_latch <= hsc_pkg::PORT_RESET;
			rdata <= '0;
			periph_run_o <= '0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
			vec_pend <= next_vec_pend;
			cpu_en <= next_cpu_en;
			vec_pulse <= next_vec_pulse;
			res_pulse <= next_res_pulse;
			rvec <= next_rvec;
			ack <= next_ack;
			bus_wait <= next_bus_wait;
			gie <= next_gie;
			wdt_opt <= next_wdt_opt;
			csel <= next_csel;
			port_latch <= next_port_latch;
			rdata <= next_rdata;
			periph_run_o <= run_comb;
		end
	end

	assign cpu_clk_en_o = cpu_en;
	assign vector_take_o = vec_pulse;
	assign resume_o = res_pulse;
	assign reset_vector_o = rvec;
	assign port_o = port_latch;
	assign avs_readdata_o = rdata;
	// Waitrequest is low only in the acknowledge cycle
	assign avs_waitrequest_o = bus_wait;

	// Cycles spent in the wake wait, for the bound check only
	int unsigned halt_len;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			halt_len <= 0;
		else
			halt_len <= (state == hsc_pkg::ST_WAIT) ? halt_len + 1 : 0;
	end

	// Processor clock and port latch while halted
	clk_off_a: assert property ( // RULE_01
		state == hsc_pkg::ST_HALT |-> !cpu_clk_en_o)
		else $error("cpu clock running in halt");
	port_hold_a: assert property ( // RULE_02
		state != hsc_pkg::ST_RUN |=> $stable(port_o))
		else $error("port latch changed in halt");

	// Peripheral gating in halt, with the high-speed oscillator stopped except in the watchdog checks
	cnt_a_gate_a: assert property ( // RULE_03
		state == hsc_pkg::ST_HALT && !osc.hs_run &&
		!csel[hsc_pkg::CSEL_CNTA_EXT] |=> !periph_run_o.counter_a)
		else $error("counter a ran without its pin clock");
	cnt_b_gate_a: assert property ( // RULE_04
		state == hsc_pkg::ST_HALT && !osc.hs_run &&
		!csel[hsc_pkg::CSEL_CNTB_EXT] |=> !periph_run_o.counter_b)
		else $error("counter b ran without its pin clock");
	tmr_a_gate_a: assert property ( // RULE_05
		state == hsc_pkg::ST_HALT && !osc.hs_run && !osc.cnta_run
		|=> !periph_run_o.interval_timer_a)
		else $error("timer a ran without counter a");
	tmr_b_stop_a: assert property ( // RULE_06
		state == hsc_pkg::ST_HALT && !osc.hs_run && !osc.int_run
		|=> !periph_run_o.interval_timer_b)
		else $error("timer b ran with no oscillator");
	watch_gate_a: assert property ( // RULE_07
		state == hsc_pkg::ST_HALT && !osc.hs_run &&
		!csel[hsc_pkg::CSEL_WATCH_SUB] |=> !periph_run_o.watch)
		else $error("watch timer ran off the wrong clock");
	wdt_run_a: assert property ( // RULE_08
		state == hsc_pkg::ST_HALT && !wdt_opt && osc.int_run
		|=> periph_run_o.watchdog)
		else $error("watchdog stopped with fixed oscillator");
	wdt_stop_a: assert property ( // RULE_09
		state == hsc_pkg::ST_HALT && wdt_opt |=> !periph_run_o.watchdog)
		else $error("watchdog ran in halt");
	async_gate_a: assert property ( // RULE_10
		state == hsc_pkg::ST_HALT && !osc.hs_run && !osc.cnta_run
		|=> !periph_run_o.async_port_a && !periph_run_o.async_port_b)
		else $error("async port ran without counter a");
	sync_port_a: assert property ( // RULE_11
		state == hsc_pkg::ST_HALT && !osc.hs_run &&
		!csel[hsc_pkg::CSEL_SYNC_EXT] |=> !periph_run_o.clocked_serial_port)
		else $error("clocked serial ran without pin clock");

	// Wake-up: unmasked request, path choice and wait length
	wake_exit_a: assert property ( // RULE_12
		state == hsc_pkg::ST_HALT && wake |=> state == hsc_pkg::ST_WAIT)
		else $error("unmasked interrupt did not end halt");
	clk_back_a: assert property ( // RULE_12
		state == hsc_pkg::ST_WAIT && wait_cnt == 4'h0 |=> cpu_clk_en_o)
		else $error("cpu clock not restarted after wake");
	vec_pick_a: assert property ( // RULE_13 RULE_14
		state == hsc_pkg::ST_HALT && wake |=> vec_pend == $past(gie))
		else $error("wake path differs from global enable");
	vec_wait_a: assert property ( // RULE_15
		state == hsc_pkg::ST_HALT && wake && gie
		|=> !vector_take_o [*8] ##1 !vector_take_o ##1 vector_take_o)
		else $error("vectored wait wrong");
	res_wait_a: assert property ( // RULE_16
		state == hsc_pkg::ST_HALT && wake && !gie
		|=> !resume_o [*3] ##1 resume_o)
		else $error("resume wait wrong");
	no_vec_a: assert property ( // RULE_14
		$rose(resume_o) |-> !vector_take_o)
		else $error("vector and resume together");
	wait_bound_a: assert property ( // RULE_15 RULE_16
		halt_len <= hsc_pkg::WAIT_VECTOR_MAX)
		else $error("wake wait too long");
	rst_exit_a: assert property ( // RULE_17
		reset_vector_o |=> !reset_vector_o && cpu_clk_en_o)
		else $error("reset vector request not followed by restart");

	// Main scenarios the bench should reach
	halt_c: cover property (state == hsc_pkg::ST_HALT);
	vec_c: cover property (vector_take_o);
	res_c: cover property (resume_o);
	wdt_halt_c: cover property (state == hsc_pkg::ST_HALT && wdt_opt);
	masked_c: cover property (state == hsc_pkg::ST_HALT &&
		|(irq_req_i & irq_mask_i));
endmodule

// ---- verilog/hsc_pkg.sv ----
// Package for the halt standby controller: constants, states and carriers
package hsc_pkg;
	// Avalon register word offsets (byte addresses)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_CSEL = 4'h8;
	localparam logic [3:0] ADDR_PORT = 4'hc;
	// Control register fields
	localparam int CTRL_HALT_BIT = 0;
	localparam int CTRL_GIE_BIT = 1;
	localparam int CTRL_WDT_OPT_BIT = 2;
	// Clock select field positions
	localparam int CSEL_CNTA_EXT = 0;
	localparam int CSEL_CNTB_EXT = 1;
	localparam int CSEL_TMA_CNTA = 2;
	localparam int CSEL_TMB_HS = 3;
	localparam int CSEL_TMB_DIV = 4;
	localparam int CSEL_WATCH_SUB = 5;
	localparam int CSEL_ASYNC_CNTA = 6;
	localparam int CSEL_SYNC_EXT = 7;
	localparam logic [7:0] CSEL_RESET = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// Wake-up waits in clocks; the upper figure of each range is used
	localparam int WAIT_VECTOR_MIN = 8;
	localparam int WAIT_VECTOR_MAX = 9;
	localparam int WAIT_RESUME_MIN = 2;
	localparam int WAIT_RESUME_MAX = 3;
	localparam logic [3:0] WAIT_VECTOR = 4'(WAIT_VECTOR_MAX);
	localparam logic [3:0] WAIT_RESUME = 4'(WAIT_RESUME_MAX);
	// Divider exponent for interval timer b from the internal oscillator
	localparam int INT_DIV_EXP = 7;

	typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAIT} hsc_state_e;

	// Oscillator status inputs
	typedef struct packed {
		logic hs_run;
		logic int_run;
		logic cnta_run;
	} hsc_osc_s;

	// Peripheral run enables during halt
	typedef struct packed {
		logic counter_a;
		logic counter_b;
		logic interval_timer_a;
		logic interval_timer_b;
		logic watch;
		logic watchdog;
		logic async_port_a;
		logic async_port_b;
		logic clocked_serial_port;
	} hsc_periph_s;
endpackage

// ---- verilog/hsc_sync.sv ----
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module hsc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	// First stage feeds only the second
	always_comb begin
		next_meta = d_i;
		next_q = meta;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= next_meta;
			q_o <= next_q;
		end
	end
endmodule

// ---- verilog/hsc_gate.sv ----
// Peripheral enable decision while halted from oscillator status and clock select
`timescale 1ns/10ps
module hsc_gate (
	input wire logic halted_i,
	input wire hsc_pkg::hsc_osc_s osc_i,
	input wire logic [7:0] csel_i,
	input wire logic wdt_opt_i,
	output hsc_pkg::hsc_periph_s run_o
);
	logic hs;
	logic cnta_on;

	assign hs = osc_i.hs_run;
	// Counter a output is usable only while it counts off its own pin
	assign cnta_on = osc_i.cnta_run && csel_i[hsc_pkg::CSEL_CNTA_EXT];

	// Outside halt everything runs; in halt the clock sources decide
	always_comb begin
		run_o = '1;
		if (halted_i) begin
			run_o.counter_a = hs || csel_i[hsc_pkg::CSEL_CNTA_EXT]; // RULE_03
			run_o.counter_b = hs || csel_i[hsc_pkg::CSEL_CNTB_EXT]; // RULE_04
			run_o.interval_timer_a = hs ||
				(csel_i[hsc_pkg::CSEL_TMA_CNTA] && cnta_on); // RULE_05
			// Both running: any source works
			if (hs && osc_i.int_run)
				run_o.interval_timer_b = 1'b1; // RULE_06
			else if (hs)
				run_o.interval_timer_b = csel_i[hsc_pkg::CSEL_TMB_HS];
			else if (osc_i.int_run)
				run_o.interval_timer_b = csel_i[hsc_pkg::CSEL_TMB_DIV];
			else
				run_o.interval_timer_b = 1'b0;
			run_o.watch = hs || csel_i[hsc_pkg::CSEL_WATCH_SUB]; // RULE_07
			// Stoppable option stops it regardless of the oscillator
			run_o.watchdog = !wdt_opt_i && osc_i.int_run; // RULE_08 RULE_09
			run_o.async_port_a = hs ||
				(csel_i[hsc_pkg::CSEL_ASYNC_CNTA] && cnta_on); // RULE_10
			run_o.async_port_b = hs ||
				(csel_i[hsc_pkg::CSEL_ASYNC_CNTA] && cnta_on); // RULE_10
			run_o.clocked_serial_port = hs ||
				csel_i[hsc_pkg::CSEL_SYNC_EXT]; // RULE_11
		end
	end
endmodule

// ---- test/hsc_partner.sv ----
// Model of the core and interrupt controller facing the halt controller
`timescale 1ns/10ps
module hsc_partner (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] raise_i,
	input wire logic [7:0] mask_i,
	input wire logic vector_take_i,
	input wire logic resume_i,
	output logic [7:0] irq_req_o,
	output logic [7:0] wait_o,
	output logic [1:0] ended_o
);
	logic [7:0] cnt;

	// Flags stay set until the core reacts; low cycles give the wait
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_req_o <= 8'h00;
			cnt <= 8'h00;
			wait_o <= 8'h00;
			ended_o <= 2'h0;
		end else if (vector_take_i | resume_i) begin
			// Software clears the flag on both paths so halt can recur
			irq_req_o <= 8'h00;
			wait_o <= cnt - 8'h01;
			ended_o <= {vector_take_i, resume_i};
			cnt <= 8'h00;
		end else begin
			irq_req_o <= irq_req_o | raise_i;
			if (|(irq_req_o & ~mask_i)) begin
				cnt <= cnt + 8'h01;
			end
		end
	end
endmodule

// ---- test/test_hsc_top.sv ----
// Self-checking bench for the halt standby controller
`timescale 1ns/10ps
module test_hsc_top;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic [31:0] got;
	logic wreq;
	logic [7:0] raise = 8'h00;
	logic [7:0] mask = 8'h00;
	logic [7:0] req;
	logic hs = 1'b1;
	logic ir = 1'b1;
	logic ca = 1'b1;
	logic cen;
	logic vec;
	logic res;
	logic rvec;
	logic [7:0] port;
	hsc_pkg::hsc_periph_s run;
	logic [7:0] wt;
	logic [1:0] ended;
	logic [23:0] r;
	int failures = 0;
	int cmp_count = 0;
	// Flags {hs,int,cnta,opt}, clock select, enables expected in halt
	logic [23:0] rows [9] = '{24'he001ff, 24'h9001d7, 24'h9081f7,
		24'h6ff1ff, 24'h600008, 24'h5ff1b1, 24'h245146, 24'h2fa091,
		24'h608008};

	always #4 core_clk_i = ~core_clk_i;

	hsc_top #(.NIRQ(8)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .irq_req_i(req), .irq_mask_i(mask),
		.hs_run_i(hs), .int_run_i(ir), .cnta_run_i(ca),
		.cpu_clk_en_o(cen), .vector_take_o(vec), .resume_o(res),
		.reset_vector_o(rvec), .port_o(port), .periph_run_o(run));
	hsc_partner core (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.raise_i(raise), .mask_i(mask), .vector_take_i(vec),
		.resume_i(res), .irq_req_o(req), .wait_o(wt), .ended_o(ended));

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Unknown counts fail outright rather than slipping past the range
	task automatic chk_rng(input logic [7:0] g, input int lo, input int hi);
		cmp_count++;
		if ($isunknown(g) || g < lo || g > hi) begin
			failures++;
			$display("Error at %0t: got %h expected %h..%h", $time, g, lo, hi);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge core_clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge core_clk_i);
		end while (wreq !== 1'b0);
		got = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic rst_seq(input int n);
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (n) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk({port, 6'h0, rvec, cen, 7'h0, run}, 32'h00020000);
		@(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk({30'h0, rvec, cen}, 32'h1);
	endtask

	task automatic halt(input logic opt, input logic gie);
		bus(1'b1, hsc_pkg::ADDR_CTRL, {29'h0, opt, gie, 1'b1});
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(32'(cen), 32'h0);
	endtask

	// Raise or unmask one request, then time the gap to the restart
	task automatic wake(input logic gie, input logic kick);
		@(posedge core_clk_i);
		raise <= {7'h0, kick};
		mask <= 8'h00;
		@(posedge core_clk_i);
		raise <= 8'h00;
		do begin
			@(negedge core_clk_i);
		end while ((vec | res) !== 1'b1);
		chk(32'(cen), 32'h1);
		@(negedge core_clk_i);
		chk(32'(ended), gie ? 32'h2 : 32'h1);
		chk_rng(wt, gie ? 8 : 2, gie ? 9 : 3);
	endtask

	// Main sequence: reset, registers, table of halt cases, odd cases
	initial begin
		rst_seq(6);
		bus(1'b0, hsc_pkg::ADDR_CSEL, 32'h0);
		chk(got, {24'h0, hsc_pkg::CSEL_RESET});
		bus(1'b1, hsc_pkg::ADDR_PORT, 32'h5a);
		bus(1'b1, 4'h2, 32'hff);
		bus(1'b0, 4'h2, 32'h0);
		chk(got, hsc_pkg::UNMAPPED_READ);
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge core_clk_i);
			hs <= r[23];
			ir <= r[22];
			ca <= r[21];
			bus(1'b1, hsc_pkg::ADDR_CSEL, {24'h0, r[19:12]});
			halt(r[20], i[0]);
			chk(32'(run[8:7]), 32'(r[8:7]));
			chk(32'(run[6]), 32'(r[6]));
			chk(32'(run[5]), 32'(r[5]));
			chk(32'(run[4]), 32'(r[4]));
			chk(32'(run[3]), 32'(r[3]));
			chk(32'(run[2:1]), 32'(r[2:1]));
			chk(32'(run[0]), 32'(r[0]));
			chk(32'(port), 32'h5a);
			wake(i[0], 1'b1);
		end
		// Masked request must not end halt; port writes are refused then
		halt(1'b0, 1'b1);
		@(posedge core_clk_i);
		mask <= 8'h01;
		raise <= 8'h01;
		@(posedge core_clk_i);
		raise <= 8'h00;
		bus(1'b1, hsc_pkg::ADDR_PORT, 32'h3c);
		bus(1'b0, hsc_pkg::ADDR_STAT, 32'h0);
		chk(got & 32'hf, 32'h7);
		repeat (10) @(negedge core_clk_i);
		chk(32'(cen), 32'h0);
		chk(32'(port), 32'h5a);
		wake(1'b1, 1'b0);
		// Reset in mid-halt ends it and restarts from the reset vector
		halt(1'b1, 1'b0);
		rst_seq(3);
		bus(1'b0, hsc_pkg::ADDR_STAT, 32'h0);
		chk(got & 32'h1, 32'h0);
		finish_test();
	end

	// Cuts a hang short; the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk_i);
		failures++;
		finish_test();
	end
endmodule
